/* File: logic/irs_fifo.sv */
`timescale 1ns/1ps
`include "irs_map.svh"

module irs_fifo #(
	parameter int WIDTH = 8
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready
);

	logic head_v_q, head_v_d, tail_v_q, tail_v_d;
	logic [WIDTH-1:0] head_q, head_d, tail_q, tail_d;
	logic push, pop;

	assign push = in_valid & ~tail_v_q;
	assign pop = out_ready & head_v_q;
	assign in_ready = ~tail_v_q;
	assign out_valid = head_v_q;
	assign out_data = head_q;

	always_comb begin
		head_v_d = head_v_q;
		head_d = head_q;
		tail_v_d = tail_v_q;
		tail_d = tail_q;
		if (pop) begin
			head_v_d = tail_v_q;
			head_d = tail_q;
			tail_v_d = 1'b0;
		end
		if (push) begin
			if (!head_v_d) begin
				head_v_d = 1'b1;
				head_d = in_data;
			end else begin
				tail_v_d = 1'b1;
				tail_d = in_data;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			head_v_q <= 1'b0;
			tail_v_q <= 1'b0;
			head_q <= '0;
			tail_q <= '0;
		end else begin
			head_v_q <= head_v_d;
			tail_v_q <= tail_v_d;
			head_q <= head_d;
			tail_q <= tail_d;
		end
	end

endmodule

/* File: logic/irs_map.svh */
`ifndef IRS_MAP_SVH
`define IRS_MAP_SVH

// Character codes of the command stream
`define IRS_CH_PER_NV 8'h50
`define IRS_CH_PER_RAM 8'h70
`define IRS_CH_THR_NV 8'h54
`define IRS_CH_THR_RAM 8'h74
`define IRS_CH_INFO 8'h49
`define IRS_CH_END 8'h78
`define IRS_CH_DOT 8'h2E
`define IRS_CH_COMMA 8'h2C
`define IRS_CH_SEC 8'h73
`define IRS_CH_MAG 8'h6D
`define IRS_CH_CR 8'h0D
`define IRS_CH_LF 8'h0A
`define IRS_CH_ZERO 8'h30
`define IRS_CH_NINE 8'h39

// Argument length in decimal digits
`define IRS_ARG_DIGITS 4'hA
// Integer digits of the threshold before the point
`define IRS_THR_INT 4'h8

// Response columns
`define IRS_COL_NVP 6'h02
`define IRS_COL_WKP 6'h0E
`define IRS_COL_NVT 6'h1A
`define IRS_COL_WKT 6'h27
`define IRS_COL_CR 6'h33
`define IRS_COL_LF 6'h34

// Timing
`define IRS_SEC_NS 1000000000
`define IRS_CLK_NS 10

`endif

/* File: logic/irs_pkg.sv */
package irs_pkg;

	typedef enum logic [1:0] {
		IRS_LOAD = 2'h0,
		IRS_IDLE = 2'h1,
		IRS_ARG = 2'h3,
		IRS_SEND = 2'h2
	} irs_state_type;

	typedef enum logic [2:0] {
		IRS_CMD_PER_NV = 3'h0,
		IRS_CMD_PER_RAM = 3'h1,
		IRS_CMD_THR_NV = 3'h2,
		IRS_CMD_THR_RAM = 3'h3,
		IRS_CMD_INFO = 3'h4
	} irs_cmd_type;

	// Period: ten BCD digits of seconds; threshold: eight integer and two fraction BCD digits
	typedef struct packed {
		logic [39:0] period;
		logic [39:0] thresh;
	} irs_settings_type;

endpackage

/* File: logic/irs_top.sv */
// How it works
// - Report only when reading magnitude exceeds working threshold; brighter ones suppressed.
// - Upper-case period command writes persistent and working period.
// - Lower-case period command writes working period only.
// - Period argument is ten decimal digits of seconds, then x.
// - Upper-case threshold command writes persistent and working threshold.
// - Lower-case threshold command writes working threshold only.
// - Threshold argument is fixed point with two decimals, then x.
// - Settings line answers the query and every period or threshold command.
// - Settings line starts with upper-case I.
// - Persistent period in columns 2-12, working period 14-24, suffix s.
// - Persistent threshold in columns 26-37, working threshold 39-50, suffix m.
// - Settings line ends with CR then LF in columns 51, 52.
// - After reset working values are loaded from persistent storage.
// - Timed report is a reading reply with serial number appended.
// - Working period zero stops timed reports.
`timescale 1ns/1ps
`include "irs_map.svh"

module irs_top #(
	parameter int SEC_CYCLES = `IRS_SEC_NS / `IRS_CLK_NS
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	output logic rx_ready,
	output logic tx_valid,
	output logic [7:0] tx_data,
	input wire logic tx_ready,
	input wire irs_pkg::irs_settings_type nv_stored,
	output logic nv_we_period,
	output logic nv_we_thresh,
	output irs_pkg::irs_settings_type nv_wdata,
	output irs_pkg::irs_settings_type work_settings,
	input wire logic [39:0] reading_mag,
	input wire logic reading_neg,
	output logic report_req
);

	irs_pkg::irs_state_type st_q, st_d;
	irs_pkg::irs_cmd_type cmd_q, cmd_d;
	irs_pkg::irs_settings_type work_q, work_d, snap_q, snap_d, nvw_q, nvw_d;
	logic [39:0] dig_q, dig_d;
	logic [3:0] ndig_q, ndig_d;
	logic [5:0] col_q, col_d;
	logic rx_ready_q, rx_ready_d, we_p_q, we_p_d, we_t_q, we_t_d;
	logic take, is_digit, is_cmd, f_ready;
	irs_pkg::irs_cmd_type cmd_of;
	logic [31:0] div_q, div_d;
	logic [39:0] sec_q, sec_d;
	logic rep_q, rep_d;

	function automatic logic [7:0] bcd_char(input logic [39:0] v, input logic [3:0] i);
		return {4'h3, 4'(v >> (6'(4) * (6'(9) - 6'(i))))};
	endfunction
	function automatic logic [39:0] bcd_inc(input logic [39:0] v);
		logic [39:0] r;
		logic c;
		r = v;
		c = 1'b1;
		for (int k = 0; k < 10; k++) begin
			if (c) begin
				if (r[4*k +: 4] == 4'h9) begin
					r[4*k +: 4] = 4'h0;
				end else begin
					r[4*k +: 4] = r[4*k +: 4] + 4'h1;
					c = 1'b0;
				end
			end
		end
		return r;
	endfunction
	function automatic logic [7:0] per_char(input logic [39:0] v, input logic [5:0] k);
		return (k < 6'hA) ? bcd_char(v, k[3:0]) : `IRS_CH_SEC;
	endfunction
	function automatic logic [7:0] thr_char(input logic [39:0] v, input logic [5:0] k);
		logic [7:0] c;
		c = `IRS_CH_MAG;
		if (k < 6'h8) begin
			c = bcd_char(v, k[3:0]);
		end else if (k == 6'h8) begin
			c = `IRS_CH_DOT;
		end else if (k < 6'hB) begin
			c = bcd_char(v, 4'(k - 6'h1));
		end
		return c;
	endfunction
	function automatic logic [7:0] resp_char(input logic [5:0] col,
			input irs_pkg::irs_settings_type nv, input irs_pkg::irs_settings_type wk);
		logic [7:0] c;
		c = `IRS_CH_COMMA;
		if (col == 6'h0) begin
			c = `IRS_CH_INFO;
		end else if (col == `IRS_COL_LF) begin
			c = `IRS_CH_LF;
		end else if (col == `IRS_COL_CR) begin
			c = `IRS_CH_CR;
		end else if (col >= `IRS_COL_WKT) begin
			c = thr_char(wk.thresh, col - `IRS_COL_WKT);
		end else if (col >= `IRS_COL_NVT && col < `IRS_COL_WKT - 6'h1) begin
			c = thr_char(nv.thresh, col - `IRS_COL_NVT);
		end else if (col >= `IRS_COL_WKP && col < `IRS_COL_NVT - 6'h1) begin
			c = per_char(wk.period, col - `IRS_COL_WKP);
		end else if (col >= `IRS_COL_NVP && col < `IRS_COL_WKP - 6'h1) begin
			c = per_char(nv.period, col - `IRS_COL_NVP);
		end
		return c;
	endfunction
	assign take = rx_valid & rx_ready_q;
	assign is_digit = (rx_data >= `IRS_CH_ZERO) && (rx_data <= `IRS_CH_NINE);
	assign is_cmd = (rx_data == `IRS_CH_PER_NV) || (rx_data == `IRS_CH_PER_RAM) ||
		(rx_data == `IRS_CH_THR_NV) || (rx_data == `IRS_CH_THR_RAM) ||
		(rx_data == `IRS_CH_INFO);
	always_comb begin
		unique case (rx_data)
			`IRS_CH_PER_NV: cmd_of = irs_pkg::IRS_CMD_PER_NV;
			`IRS_CH_PER_RAM: cmd_of = irs_pkg::IRS_CMD_PER_RAM;
			`IRS_CH_THR_NV: cmd_of = irs_pkg::IRS_CMD_THR_NV;
			`IRS_CH_THR_RAM: cmd_of = irs_pkg::IRS_CMD_THR_RAM;
			default: cmd_of = irs_pkg::IRS_CMD_INFO;
		endcase
	end

	// Parser, settings store and response emitter
	always_comb begin
		st_d = st_q;
		cmd_d = cmd_q;
		work_d = work_q;
		snap_d = snap_q;
		nvw_d = nvw_q;
		dig_d = dig_q;
		ndig_d = ndig_q;
		col_d = col_q;
		we_p_d = 1'b0;
		we_t_d = 1'b0;
		unique case (st_q)
			irs_pkg::IRS_LOAD: begin
				work_d = nv_stored;
				st_d = irs_pkg::IRS_IDLE;
			end
			irs_pkg::IRS_IDLE: begin
				if (take && is_cmd) begin
					cmd_d = cmd_of;
					dig_d = '0;
					ndig_d = 4'h0;
					st_d = irs_pkg::IRS_ARG;
				end
			end
			irs_pkg::IRS_ARG: begin
				if (take) begin
					if (is_digit && cmd_q != irs_pkg::IRS_CMD_INFO && ndig_q < `IRS_ARG_DIGITS) begin
						dig_d = {dig_q[35:0], rx_data[3:0]};
						ndig_d = ndig_q + 4'h1;
					end else if (rx_data == `IRS_CH_DOT && ndig_q == `IRS_THR_INT &&
							(cmd_q == irs_pkg::IRS_CMD_THR_NV || cmd_q == irs_pkg::IRS_CMD_THR_RAM)) begin
						st_d = irs_pkg::IRS_ARG;
					end else if (rx_data == `IRS_CH_END &&
							(cmd_q == irs_pkg::IRS_CMD_INFO || ndig_q == `IRS_ARG_DIGITS)) begin
						snap_d = nv_stored;
						unique case (cmd_q)
							irs_pkg::IRS_CMD_PER_NV: begin
								work_d.period = dig_q;
								snap_d.period = dig_q;
								nvw_d.period = dig_q;
								we_p_d = 1'b1;
							end
							irs_pkg::IRS_CMD_PER_RAM: begin
								work_d.period = dig_q;
							end
							irs_pkg::IRS_CMD_THR_NV: begin
								work_d.thresh = dig_q;
								snap_d.thresh = dig_q;
								nvw_d.thresh = dig_q;
								we_t_d = 1'b1;
							end
							irs_pkg::IRS_CMD_THR_RAM: begin
								work_d.thresh = dig_q;
							end
							default: snap_d = nv_stored;
						endcase
						col_d = 6'h0;
						st_d = irs_pkg::IRS_SEND;
					end else if (is_cmd) begin
						cmd_d = cmd_of;
						dig_d = '0;
						ndig_d = 4'h0;
					end else begin
						st_d = irs_pkg::IRS_IDLE;
					end
				end
			end
			irs_pkg::IRS_SEND: begin
				if (f_ready) begin
					col_d = col_q + 6'h1;
					if (col_q == `IRS_COL_LF) begin
						st_d = irs_pkg::IRS_IDLE;
					end
				end
			end
		endcase
		rx_ready_d = (st_d == irs_pkg::IRS_IDLE) || (st_d == irs_pkg::IRS_ARG);
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			st_q <= irs_pkg::IRS_LOAD;
			cmd_q <= irs_pkg::IRS_CMD_INFO;
			work_q <= '0;
			snap_q <= '0;
			nvw_q <= '0;
			dig_q <= '0;
			ndig_q <= 4'h0;
			col_q <= 6'h0;
			rx_ready_q <= 1'b0;
			we_p_q <= 1'b0;
			we_t_q <= 1'b0;
		end else begin
			st_q <= st_d;
			cmd_q <= cmd_d;
			work_q <= work_d;
			snap_q <= snap_d;
			nvw_q <= nvw_d;
			dig_q <= dig_d;
			ndig_q <= ndig_d;
			col_q <= col_d;
			rx_ready_q <= rx_ready_d;
			we_p_q <= we_p_d;
			we_t_q <= we_t_d;
		end
	end

	irs_fifo #(.WIDTH(8)) u_fifo (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.in_valid(st_q == irs_pkg::IRS_SEND),
		.in_data(resp_char(col_q, snap_q, work_q)),
		.in_ready(f_ready),
		.out_valid(tx_valid),
		.out_data(tx_data),
		.out_ready(tx_ready)
	);

	// Seconds divider and interval timer
	always_comb begin
		div_d = div_q + 32'h1;
		sec_d = sec_q;
		rep_d = 1'b0;
		if (div_q == 32'(SEC_CYCLES - 1)) begin
			div_d = 32'h0;
			if (work_q.period == 40'h0) begin
				sec_d = 40'h0;
			end else if (bcd_inc(sec_q) >= work_q.period) begin
				sec_d = 40'h0;
				// darker than threshold only; formatter appends serial
				rep_d = !reading_neg && (reading_mag > work_q.thresh);
			end else begin
				sec_d = bcd_inc(sec_q);
			end
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			div_q <= 32'h0;
			sec_q <= 40'h0;
			rep_q <= 1'b0;
		end else begin
			div_q <= div_d;
			sec_q <= sec_d;
			rep_q <= rep_d;
		end
	end

	assign rx_ready = rx_ready_q;
	assign nv_we_period = we_p_q;
	assign nv_we_thresh = we_t_q;
	assign nv_wdata = nvw_q;
	assign work_settings = work_q;
	assign report_req = rep_q;

endmodule

/* File: testbench/irs_host.sv */
`timescale 1ns/1ps
module irs_host (
	input wire logic sys_clk,
	output logic rx_valid,
	output logic [7:0] rx_data,
	input wire logic rx_ready,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	output logic tx_ready,
	input wire logic slow
);
	logic [7:0] got[$];
	initial begin
		rx_valid = 1'b0;
		rx_data = 8'h00;
		tx_ready = 1'b1;
	end
	task automatic send(input string s);
		for (int i = 0; i < s.len(); i++) begin
			rx_valid <= 1'b1;
			rx_data <= s[i];
			@(posedge sys_clk);
			while (!rx_ready) @(posedge sys_clk);
		end
		rx_valid <= 1'b0;
		rx_data <= ~s[s.len()-1];
		@(posedge sys_clk);
	endtask
	// Sink stalls every other cycle when slow
	always @(posedge sys_clk) begin
		if (tx_valid && tx_ready) got.push_back(tx_data);
		tx_ready <= !slow || !tx_ready;
	end
endmodule

/* File: testbench/irs_props.sv */
`timescale 1ns/1ps
module irs_props #(
	parameter int SEC_CYCLES = 10
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	input wire logic tx_ready,
	input wire irs_pkg::irs_settings_type nv_stored,
	input wire logic nv_we_period,
	input wire logic nv_we_thresh,
	input wire irs_pkg::irs_settings_type nv_wdata,
	input wire irs_pkg::irs_settings_type work_settings,
	input wire logic [39:0] reading_mag,
	input wire logic reading_neg,
	input wire logic report_req
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!reset_n);

	rep_pulse_a: assert property (report_req |=> !report_req)
		else $error("report request too long");
	rep_dark_a: assert property (report_req |-> !$past(reading_neg)
		&& $past(reading_mag) > $past(work_settings.thresh)) else $error("report not dark");
	rep_off_a: assert property ((work_settings.period == 40'h0)[*3] |=> !report_req)
		else $error("report with zero period");
	nvp_data_a: assert property (nv_we_period |-> nv_wdata.period == work_settings.period)
		else $error("stored period differs");
	nvt_data_a: assert property (nv_we_thresh |-> nv_wdata.thresh == work_settings.thresh)
		else $error("stored threshold differs");
	tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
		else $error("stalled byte lost");
	boot_load_a: assert property (!$past(reset_n) |=> work_settings == nv_stored)
		else $error("working values not loaded");
	resp_head_a: assert property (nv_we_period || nv_we_thresh |->
		##[1:3] tx_valid && tx_data == 8'h49) else $error("no settings line");

	cover property (report_req);
	cover property (nv_we_thresh);
	cover property (tx_valid && !tx_ready);
endmodule

bind irs_top irs_props #(.SEC_CYCLES(SEC_CYCLES)) i_props (.sys_clk, .reset_n, .tx_valid,
	.tx_data, .tx_ready, .nv_stored, .nv_we_period, .nv_we_thresh, .nv_wdata,
	.work_settings, .reading_mag, .reading_neg, .report_req);

/* File: testbench/testbench.sv */
`timescale 1ns/1ps
module testbench;
	logic sys_clk, reset_n, rx_valid, rx_ready, tx_valid, tx_ready, slow;
	logic [7:0] rx_data, tx_data;
	logic nv_we_period, nv_we_thresh, reading_neg, report_req;
	logic [39:0] reading_mag;
	irs_pkg::irs_settings_type nv_stored, nv_wdata, work_settings, exp_nv, exp_wk;
	int n_errors, n_tests, n_cyc, n_rep;

	irs_top #(.SEC_CYCLES(10)) i_dut (.sys_clk, .reset_n, .rx_valid, .rx_data, .rx_ready,
		.tx_valid, .tx_data, .tx_ready, .nv_stored, .nv_we_period, .nv_we_thresh,
		.nv_wdata, .work_settings, .reading_mag, .reading_neg, .report_req);
	irs_host i_host (.sys_clk, .rx_valid, .rx_data, .rx_ready, .tx_valid, .tx_data,
		.tx_ready, .slow);

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// Persistent store, cycle counter and hang guard
	always @(posedge sys_clk) begin
		n_cyc++;
		if (nv_we_period) nv_stored.period <= nv_wdata.period;
		if (nv_we_thresh) nv_stored.thresh <= nv_wdata.thresh;
		if (report_req) n_rep++;
		if (n_cyc > 5000) begin
			n_errors++;
			finish_test();
		end
	end

	task check(input string what, input logic [79:0] exp, input logic [79:0] got);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task line_check();
		string e;
		e = $sformatf("I,%hs,%hs,%h.%hm,%h.%hm\015\012", exp_nv.period, exp_wk.period,
			exp_nv.thresh[39:8], exp_nv.thresh[7:0], exp_wk.thresh[39:8], exp_wk.thresh[7:0]);
		for (int i = 0; i < 300 && i_host.got.size() < 53; i++) @(posedge sys_clk);
		check("line length", 53, i_host.got.size());
		for (int i = 0; i < i_host.got.size(); i++) check("line byte", e[i], i_host.got[i]);
		i_host.got.delete();
	endtask

	task t_reset();
		reset_n <= 1'b0;
		repeat (10) @(posedge sys_clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge sys_clk);
		check("boot working", nv_stored, work_settings);
		exp_nv = nv_stored;
		exp_wk = nv_stored;
		$display("t_reset end");
	endtask

	task t_query();
		slow <= 1'b1;
		i_host.send("Ix");
		line_check();
		slow <= 1'b0;
		$display("t_query end");
	endtask

	task t_cmd(input string c, input logic [39:0] v);
		if (c == "t" || c == "T") begin
			i_host.send($sformatf("%s%h.%hx", c, v[39:8], v[7:0]));
			exp_wk.thresh = v;
			if (c == "T") exp_nv.thresh = v;
		end else begin
			i_host.send($sformatf("%s%hx", c, v));
			exp_wk.period = v;
			if (c == "P") exp_nv.period = v;
		end
		line_check();
		check("working", exp_wk, work_settings);
		check("stored", exp_nv, nv_stored);
		$display("t_cmd %s end", c);
	endtask

	task t_abort();
		i_host.send("p12x");
		i_host.send("p00000000001x");
		repeat (50) @(posedge sys_clk);
		check("abort bytes", 0, i_host.got.size());
		check("abort working", exp_wk, work_settings);
		$display("t_abort end");
	endtask

	task t_timer();
		int gap;
		reading_mag <= 40'h0000001601;
		t_cmd("p", 40'h3);
		for (int i = 0; i < 100 && !report_req; i++) @(posedge sys_clk);
		@(posedge sys_clk);
		for (gap = 1; gap < 100 && !report_req; gap++) @(posedge sys_clk);
		check("report gap", 30, gap);
		@(posedge sys_clk);
		reading_mag <= 40'h0000001600;
		n_rep = 0;
		repeat (80) @(posedge sys_clk);
		check("equal reading", 0, n_rep);
		reading_mag <= 40'h0000009999;
		reading_neg <= 1'b1;
		n_rep = 0;
		repeat (80) @(posedge sys_clk);
		check("negative reading", 0, n_rep);
		reading_neg <= 1'b0;
		t_cmd("p", 40'h0);
		n_rep = 0;
		repeat (80) @(posedge sys_clk);
		check("period zero", 0, n_rep);
		$display("t_timer end");
	endtask

	task finish_test();
		$display("tests %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	initial begin
		reset_n = 1'b0;
		slow = 1'b0;
		reading_mag = 40'h0;
		reading_neg = 1'b0;
		n_errors = 0;
		n_tests = 0;
		n_cyc = 0;
		n_rep = 0;
		nv_stored = {40'h0000000360, 40'h0000001760};
		t_reset();
		t_query();
		t_cmd("P", 40'h0000000720);
		t_cmd("p", 40'h0000000005);
		t_cmd("T", 40'h0000001725);
		t_cmd("t", 40'h0000001600);
		t_abort();
		t_timer();
		t_reset();
		finish_test();
	end
endmodule
